// [hdl/erictl_ctrl.sv]
// Reset sequencing, interrupt detection and priority with AHB-Lite registers
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "erictl_regs.svh"

module erictl_ctrl (
  // Clock and power-on reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Request pins, active low except nonmask_pin_n when NMSEL selects its rising edge, asynchronous
  input  wire logic        external_clear_pin_n,
  input  wire logic        nonmask_pin_n,
  input  wire logic [7:0]  ext_request_n,
  input  wire logic [15:0] key_sense_inputs_n,
  // On-chip peripherals, same clock
  input  wire logic [25:0] periph_request,
  input  wire logic        watchdog_reset_pulse,
  input  wire logic        watchdog_nonmask_pulse,
  // CPU core
  input  wire logic        cpu_insn_boundary,
  input  wire logic        cpu_flag_manip_done,
  input  wire logic        cpu_imask,
  output logic             chip_reset_n,
  output logic             reset_vector_fetch,
  output logic             int_accept,
  output logic [5:0]       int_vector,
  output logic [15:0]      vector_addr,
  output logic             set_imask
);

  // Lowest set bit wins; index 0 is the nonmaskable source
  function automatic logic [5:0] pick_source(input logic [`ERICTL_NUM_SRC-1:0] req);
    logic [5:0] idx;
    idx = `ERICTL_VEC_NONE;
    for (int i = `ERICTL_NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 6'(i);
      end
    end
    return idx;
  endfunction

  // Word address of a vector; 0 and 3..37 only, so 2..5 never appear
  function automatic logic [15:0] vec_to_addr(input logic [5:0] vec);
    return {9'h000, vec, 1'b0};
  endfunction

  // Register map decode
  function automatic logic hit(input logic [31:0] addr, input logic [15:0] idx);
    return (addr[31:18] == 14'h0000) && (addr[17:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // Two-flop synchronisers
  logic        clr_s1_q, clr_s2_q;
  logic        nmi_s1_q, nmi_s2_q, nmi_prev_q;
  logic [7:0]  irq_s1_q, irq_s2_q;
  logic [15:0] key_s1_q, key_s2_q;
  logic [7:0]  irq_prev_q;
  logic [7:0]  irq_line_n;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clr_s1_q   <= 1'b0;
      clr_s2_q   <= 1'b0;
      nmi_s1_q   <= 1'b1;
      nmi_s2_q   <= 1'b1;
      nmi_prev_q <= 1'b1;
      irq_s1_q   <= 8'hFF;
      irq_s2_q   <= 8'hFF;
      irq_prev_q <= 8'hFF;
      key_s1_q   <= 16'hFFFF;
      key_s2_q   <= 16'hFFFF;
    end else begin
      clr_s1_q   <= external_clear_pin_n;
      clr_s2_q   <= clr_s1_q;
      nmi_s1_q   <= nonmask_pin_n;
      nmi_s2_q   <= nmi_s1_q;
      nmi_prev_q <= nmi_s2_q;
      irq_s1_q   <= ext_request_n;
      irq_s2_q   <= irq_s1_q;
      irq_prev_q <= irq_line_n;
      key_s1_q   <= key_sense_inputs_n;
      key_s2_q   <= key_s1_q;
    end
  end

  // Reset state machine
  erictl_pkg::erictl_rst_state_t rst_q, rst_d;
  logic [9:0]                    wdt_cnt_q;
  logic                          in_reset;
  logic                          first_block_q;

  always_comb begin
    rst_d = rst_q;
    case (rst_q)
      erictl_pkg::ERICTL_RUN: begin
        if (!clr_s2_q) begin
          rst_d = erictl_pkg::ERICTL_EXT_HOLD;
        end else if (watchdog_reset_pulse) begin
          rst_d = erictl_pkg::ERICTL_WDT_HOLD;
        end
      end
      erictl_pkg::ERICTL_EXT_HOLD: begin
        if (clr_s2_q) begin
          rst_d = erictl_pkg::ERICTL_VECTOR;
        end
      end
      erictl_pkg::ERICTL_WDT_HOLD: begin
        if (!clr_s2_q) begin
          rst_d = erictl_pkg::ERICTL_EXT_HOLD;
        end else if (wdt_cnt_q == 10'd1) begin
          rst_d = erictl_pkg::ERICTL_VECTOR;
        end
      end
      erictl_pkg::ERICTL_VECTOR: begin
        rst_d = clr_s2_q ? erictl_pkg::ERICTL_RUN : erictl_pkg::ERICTL_EXT_HOLD;
      end
      default: begin
        rst_d = erictl_pkg::ERICTL_EXT_HOLD;
      end
    endcase
  end

  assign in_reset = (rst_q == erictl_pkg::ERICTL_EXT_HOLD) ||
                    (rst_q == erictl_pkg::ERICTL_WDT_HOLD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_q <= erictl_pkg::ERICTL_EXT_HOLD;
    end else begin
      rst_q <= rst_d;
    end
  end

  // Pulse width counted from entry, so the hold lasts exactly the pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_cnt_q <= 10'd0;
    end else if (rst_q == erictl_pkg::ERICTL_RUN && clr_s2_q && watchdog_reset_pulse) begin
      wdt_cnt_q <= `ERICTL_WDT_PULSE;
    end else if (wdt_cnt_q != 10'd0) begin
      wdt_cnt_q <= wdt_cnt_q - 10'd1;
    end
  end

  // Registers
  logic [7:0] sysctl_q, sense_q, enable_q, keylo_q, keyhi_q;
  logic [7:0] sysctl_d, sense_d, enable_d, keylo_d, keyhi_d;
  logic       wr_pend_q;
  logic [15:0] wr_idx_q;
  logic       wr_now;
  logic [7:0] wbyte;

  assign wr_now = wr_pend_q;
  assign wbyte  = hwdata[7:0];

  always_comb begin
    sysctl_d = sysctl_q;
    sense_d  = sense_q;
    enable_d = enable_q;
    keylo_d  = keylo_q;
    keyhi_d  = keyhi_q;
    if (wr_now) begin
      case (wr_idx_q)
        `ERICTL_IDX_SYSCTL: begin
          sysctl_d = {wbyte[7:4], sysctl_q[`ERICTL_SYS_XRST], wbyte[2:0]};
        end
        `ERICTL_IDX_SENSE:  sense_d  = wbyte;
        `ERICTL_IDX_ENABLE: enable_d = wbyte;
        `ERICTL_IDX_KEYLO:  keylo_d  = wbyte;
        `ERICTL_IDX_KEYHI:  keyhi_d  = wbyte;
        default: begin
        end
      endcase
    end
  end

  // Chip reset returns every register to its initial value except XRST, which a watchdog reset clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysctl_q <= `ERICTL_RST_SYSCTL;
      sense_q  <= `ERICTL_RST_SENSE;
      enable_q <= `ERICTL_RST_ENABLE;
      keylo_q  <= `ERICTL_RST_KEYLO;
      keyhi_q  <= `ERICTL_RST_KEYHI;
    end else if (in_reset) begin
      sysctl_q <= `ERICTL_RST_SYSCTL;
      sysctl_q[`ERICTL_SYS_XRST] <= (rst_q == erictl_pkg::ERICTL_EXT_HOLD);
      sense_q  <= `ERICTL_RST_SENSE;
      enable_q <= `ERICTL_RST_ENABLE;
      keylo_q  <= `ERICTL_RST_KEYLO;
      keyhi_q  <= `ERICTL_RST_KEYHI;
    end else begin
      sysctl_q <= sysctl_d;
      sense_q  <= sense_d;
      enable_q <= enable_d;
      keylo_q  <= keylo_d;
      keyhi_q  <= keyhi_d;
    end
  end

  // Request 6 also low when any unmasked key input is low
  logic       key_any;

  assign key_any = |(~key_s2_q & ~{keyhi_q, keylo_q});
  always_comb begin
    irq_line_n = irq_s2_q;
    irq_line_n[`ERICTL_KEY_IRQ] = irq_s2_q[`ERICTL_KEY_IRQ] & ~key_any;
  end

  // Edge detection
  logic       nmi_edge;
  logic [7:0] irq_fall;

  assign nmi_edge = sysctl_q[`ERICTL_SYS_NMSEL] ? (nmi_s2_q & ~nmi_prev_q)
                                                : (~nmi_s2_q & nmi_prev_q);
  assign irq_fall = irq_prev_q & ~irq_line_n & enable_q & sense_q;

  // Acceptance
  logic                        nmi_pend_q;
  logic [7:0]                  irq_pend_q;
  logic [`ERICTL_NUM_SRC-1:0]  src_req;
  logic [7:0]                  irq_req;
  logic [5:0]                  win;
  logic                        take;
  logic                        take_nmi;
  logic [7:0]                  take_irq;

  // Level sense requests while enabled and low; edge sense from the latch
  assign irq_req = (sense_q & irq_pend_q) | (~sense_q & enable_q & ~irq_line_n);

  always_comb begin
    src_req = '0;
    src_req[0] = nmi_pend_q;
    if (!cpu_imask) begin
      src_req[`ERICTL_NUM_EXT:1] = irq_req;
      src_req[`ERICTL_NUM_SRC-1:`ERICTL_NUM_EXT+1] = periph_request;
    end
  end

  assign win  = pick_source(src_req);
  assign take = cpu_insn_boundary && !cpu_flag_manip_done && !first_block_q &&
                (rst_q == erictl_pkg::ERICTL_RUN) && (win != `ERICTL_VEC_NONE);
  assign take_nmi = take && (win == 6'd0);

  always_comb begin
    take_irq = 8'h00;
    for (int i = 0; i < `ERICTL_NUM_EXT; i++) begin
      take_irq[i] = take && (win == 6'(i + 1));
    end
  end

  // Set wins over clear on every latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_pend_q <= 1'b0;
    end else if (in_reset) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_edge || watchdog_nonmask_pulse) begin
      nmi_pend_q <= 1'b1;
    end else if (take_nmi) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // Clearing edge latches needs mask set with sense and enable both zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pend_q <= 8'h00;
    end else if (in_reset) begin
      irq_pend_q <= 8'h00;
    end else begin
      irq_pend_q <= irq_fall |
                    (irq_pend_q & ~(take_irq & sense_q) &
                     ~({8{cpu_imask}} & ~sense_q & ~enable_q));
    end
  end

  // First instruction after reset always runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_block_q <= 1'b1;
    end else if (rst_q != erictl_pkg::ERICTL_RUN) begin
      first_block_q <= 1'b1;
    end else if (cpu_insn_boundary) begin
      first_block_q <= 1'b0;
    end
  end

  // CPU side outputs
  logic [5:0] last_vec_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chip_reset_n       <= 1'b0;
      reset_vector_fetch <= 1'b0;
      int_accept         <= 1'b0;
      int_vector         <= `ERICTL_VEC_RESET;
      vector_addr        <= 16'h0000;
      set_imask          <= 1'b0;
      last_vec_q         <= `ERICTL_VEC_RESET;
    end else begin
      chip_reset_n       <= !in_reset;
      reset_vector_fetch <= (rst_q == erictl_pkg::ERICTL_VECTOR) && clr_s2_q;
      int_accept         <= take;
      set_imask          <= take || ((rst_q == erictl_pkg::ERICTL_VECTOR) && clr_s2_q);
      if (rst_q == erictl_pkg::ERICTL_VECTOR) begin
        int_vector  <= `ERICTL_VEC_RESET;
        vector_addr <= vec_to_addr(`ERICTL_VEC_RESET);
      end else if (take) begin
        int_vector  <= win + `ERICTL_VEC_NMI;
        vector_addr <= vec_to_addr(win + `ERICTL_VEC_NMI);
        last_vec_q  <= win + `ERICTL_VEC_NMI;
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  logic       addr_ok;
  logic [7:0] rd_byte;

  assign addr_ok   = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 16'h0000;
    end else begin
      wr_pend_q <= addr_ok && hwrite && (haddr[31:18] == 14'h0000);
      wr_idx_q  <= haddr[17:2];
    end
  end

  // Reads see a write completing in the same cycle
  always_comb begin
    rd_byte = 8'h00;
    if (hit(haddr, `ERICTL_IDX_SYSCTL)) begin
      rd_byte = sysctl_d;
    end else if (hit(haddr, `ERICTL_IDX_SENSE)) begin
      rd_byte = sense_d;
    end else if (hit(haddr, `ERICTL_IDX_ENABLE)) begin
      rd_byte = enable_d;
    end else if (hit(haddr, `ERICTL_IDX_KEYLO)) begin
      rd_byte = keylo_d;
    end else if (hit(haddr, `ERICTL_IDX_KEYHI)) begin
      rd_byte = keyhi_d;
    end else if (hit(haddr, `ERICTL_IDX_PEND)) begin
      rd_byte = irq_pend_q;
    end else if (hit(haddr, `ERICTL_IDX_STAT)) begin
      rd_byte = {nmi_pend_q, 1'b0, last_vec_q};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

endmodule

// [hdl/erictl_pkg.sv]
// Types shared by the exception and interrupt controller
package erictl_pkg;

  typedef enum logic [1:0] {
    ERICTL_RUN,
    ERICTL_EXT_HOLD,
    ERICTL_WDT_HOLD,
    ERICTL_VECTOR
  } erictl_rst_state_t;

endpackage

// [hdl/erictl_regs.svh]
// Register indices, field positions, reset values and counts of the exception controller
`ifndef ERICTL_REGS_SVH
`define ERICTL_REGS_SVH

// Register indices; byte address is four times the index
`define ERICTL_IDX_SYSCTL      16'hFFC4
`define ERICTL_IDX_SENSE       16'hFFC6
`define ERICTL_IDX_ENABLE      16'hFFC7
`define ERICTL_IDX_KEYLO       16'hFFF1
`define ERICTL_IDX_KEYHI       16'hFFF3
`define ERICTL_IDX_PEND        16'hFFE0
`define ERICTL_IDX_STAT        16'hFFE1

// Reset values
`define ERICTL_RST_SYSCTL      8'h09
`define ERICTL_RST_SENSE       8'h00
`define ERICTL_RST_ENABLE      8'h00
`define ERICTL_RST_KEYLO       8'hBF
`define ERICTL_RST_KEYHI       8'hFF

// Field positions
`define ERICTL_SYS_XRST        3
`define ERICTL_SYS_NMSEL       2
`define ERICTL_STAT_NMI        7

// Watchdog reset pulse width in system clocks
`define ERICTL_WDT_PULSE       10'd518

// Vector numbers and address arithmetic
`define ERICTL_VEC_RESET       6'h00
`define ERICTL_VEC_NMI         6'h03
`define ERICTL_VEC_NONE        6'h3F
`define ERICTL_NUM_SRC         35
`define ERICTL_NUM_PERIPH      26
`define ERICTL_NUM_EXT         8
`define ERICTL_NUM_KEY         16
`define ERICTL_KEY_IRQ         6

`endif

// [tb/erictl_checker.sv]
// Assertion checker for the exception and interrupt controller
`timescale 1ns/1ps
module erictl_checker (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Requests and CPU side
  input wire logic        watchdog_reset_pulse,
  input wire logic        cpu_insn_boundary,
  input wire logic        cpu_flag_manip_done,
  input wire logic        cpu_imask,
  input wire logic        chip_reset_n,
  input wire logic        reset_vector_fetch,
  input wire logic        int_accept,
  input wire logic [5:0]  int_vector,
  input wire logic [15:0] vector_addr,
  input wire logic        set_imask
);
  logic [9:0] low_cnt_q;
  logic       wdt_q;
  logic       fresh_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Low cycles counted so the watchdog hold width is checked exactly
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_q <= 10'h000;
      wdt_q     <= 1'b0;
      fresh_q   <= 1'b0;
    end else begin
      low_cnt_q <= chip_reset_n ? 10'h000 : low_cnt_q + 10'h001;
      wdt_q     <= watchdog_reset_pulse | (wdt_q & ~(chip_reset_n & (|low_cnt_q)));
      fresh_q   <= reset_vector_fetch | (fresh_q & ~cpu_insn_boundary);
    end
  end
  a_at_boundary: assert property (int_accept |->
    $past(cpu_insn_boundary & ~cpu_flag_manip_done)) else $error("accept off boundary");
  a_mask_honoured: assert property (int_accept && int_vector != 6'h03 |->
    !$past(cpu_imask)) else $error("masked source accepted");
  a_first_refused: assert property (fresh_q && cpu_insn_boundary |=>
    !int_accept) else $error("accept before first instruction");
  a_vec_addr: assert property (int_accept |->
    vector_addr == {9'h000, int_vector, 1'b0}) else $error("vector address mismatch");
  a_vec_range: assert property (int_accept |->
    int_vector inside {[6'h03:6'h25]}) else $error("vector out of range");
  a_fetch_vec: assert property (reset_vector_fetch |->
    int_vector == 6'h00 && vector_addr == 16'h0000 && set_imask && !int_accept)
    else $error("bad reset fetch");
  a_reset_quiet: assert property (!chip_reset_n && $past(!chip_reset_n) |->
    !int_accept) else $error("accept during reset");
  a_wdt_width: assert property ($rose(chip_reset_n) && wdt_q |->
    low_cnt_q == 10'h206) else $error("watchdog hold width wrong");
  a_set_mask: assert property (int_accept |-> set_imask)
    else $error("accept without mask set");
  c_nonmask: cover property (int_accept && int_vector == 6'h03);
  c_wdt: cover property ($rose(chip_reset_n) && wdt_q);
  c_first: cover property (fresh_q && cpu_insn_boundary);
endmodule
bind erictl_ctrl erictl_checker i_chk (
  .hclk(hclk), .hresetn(hresetn), .watchdog_reset_pulse(watchdog_reset_pulse),
  .cpu_insn_boundary(cpu_insn_boundary), .cpu_flag_manip_done(cpu_flag_manip_done),
  .cpu_imask(cpu_imask), .chip_reset_n(chip_reset_n),
  .reset_vector_fetch(reset_vector_fetch), .int_accept(int_accept),
  .int_vector(int_vector), .vector_addr(vector_addr), .set_imask(set_imask)
);

// [tb/erictl_cpu_model.sv]
// Behavioural CPU core model facing the controller
`timescale 1ns/1ps
module erictl_cpu_model (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // From the controller
  input  wire logic chip_reset_n,
  input  wire logic reset_vector_fetch,
  input  wire logic set_imask,
  // Bench commands
  input  wire logic slow,
  input  wire logic imask_clr,
  input  wire logic fm_req,
  // To the controller
  output logic      cpu_insn_boundary,
  output logic      cpu_flag_manip_done,
  output logic      cpu_imask
);
  logic       run_q;
  logic [3:0] gap_q;
  // No boundaries until the reset vector has been fetched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q     <= 1'b0;
      gap_q     <= 4'h0;
      cpu_imask <= 1'b1;
    end else begin
      run_q     <= chip_reset_n & (run_q | reset_vector_fetch);
      gap_q     <= (gap_q == 4'h0) ? (slow ? 4'hB : 4'h3) : gap_q - 4'h1;
      cpu_imask <= ~chip_reset_n | set_imask | (cpu_imask & ~imask_clr);
    end
  end
  assign cpu_insn_boundary   = run_q & (gap_q == 4'h0);
  assign cpu_flag_manip_done = cpu_insn_boundary & fm_req;
endmodule

// [tb/exception_reset_interrupt_ctrl_tb_top.sv]
// Self-checking bench for the exception and interrupt controller
`timescale 1ns/1ps
`include "erictl_regs.svh"
module exception_reset_interrupt_ctrl_tb_top;
  localparam logic [15:0] IDX [6] = '{`ERICTL_IDX_SYSCTL, `ERICTL_IDX_SENSE,
    `ERICTL_IDX_ENABLE, `ERICTL_IDX_KEYLO, `ERICTL_IDX_KEYHI, 16'h0100};
  localparam logic [7:0]  RST [6] = '{8'h09, 8'h00, 8'h00, 8'hBF, 8'hFF, 8'h00};
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        clr_n, nm_n, wdr, wdn, bnd, fmd, imask, slow, iclr, fm;
  logic        crst_n, fetch, acc, set_im;
  logic [7:0]  ext_n, rd;
  logic [15:0] key_n, vaddr;
  logic [25:0] periph;
  logic [5:0]  vec;
  integer      seed, bad_count, n_tests, i, a, b, c;
  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  erictl_ctrl i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .external_clear_pin_n(clr_n), .nonmask_pin_n(nm_n), .ext_request_n(ext_n),
    .key_sense_inputs_n(key_n), .periph_request(periph), .watchdog_reset_pulse(wdr),
    .watchdog_nonmask_pulse(wdn), .cpu_insn_boundary(bnd), .cpu_flag_manip_done(fmd),
    .cpu_imask(imask), .chip_reset_n(crst_n), .reset_vector_fetch(fetch),
    .int_accept(acc), .int_vector(vec), .vector_addr(vaddr), .set_imask(set_im)
  );
  erictl_cpu_model i_cpu (
    .hclk(hclk), .hresetn(hresetn), .chip_reset_n(crst_n), .reset_vector_fetch(fetch),
    .set_imask(set_im), .slow(slow), .imask_clr(iclr), .fm_req(fm),
    .cpu_insn_boundary(bnd), .cpu_flag_manip_done(fmd), .cpu_imask(imask)
  );
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic hold;
    for (int k = 0; k < 50; k++) begin
      @(posedge hclk);
      if (hready === 1'b1) return;
    end
    bad_count++;
    conclude;
  endtask
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {14'h0000, idx, 2'h0};
    hold;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    hold;
    rd = hrdata[7:0];
  endtask
  task automatic expect_vec(input logic f, input logic [5:0] v);
    for (int k = 0; k < 1000; k++) begin
      @(posedge hclk);
      #1;
      if ((f ? fetch : acc) === 1'b1) begin
        chk({10'h000, vec}, {10'h000, v});
        chk(vaddr, {9'h000, v, 1'b0});
        return;
      end
    end
    bad_count++;
    conclude;
  endtask
  task automatic unmask;
    tick(1);
    iclr <= 1'b1;
    tick(1);
    iclr <= 1'b0;
  endtask
  initial begin
    seed = 32'h0000543D;
    bad_count = 0;
    n_tests = 0;
    {hclk, hresetn, hsel, hwrite, wdr, wdn, slow, iclr, fm} = 9'h000;
    {haddr, hwdata, htrans, periph} = 92'h0;
    hsize = 3'h2;
    {clr_n, nm_n, ext_n, key_n} = 26'h3FFFFFF;
    tick(4);
    hresetn <= 1'b1;
    expect_vec(1'b1, 6'h00);
    for (i = 0; i < 6; i++) begin
      bus(1'b0, IDX[i], 8'h00);
      chk({8'h00, rd}, {8'h00, RST[i]});
    end
    for (i = 0; i < 5; i++) begin
      a = $random(seed);
      bus(1'b1, IDX[i], a[7:0]);
      bus(1'b0, IDX[i], 8'h00);
      chk({8'h00, rd}, {8'h00, a[7:4], (i == 0) | a[3], a[2:0]});
    end
    bus(1'b1, `ERICTL_IDX_SYSCTL, 8'h09);
    bus(1'b1, `ERICTL_IDX_SENSE, 8'hFF);
    bus(1'b1, `ERICTL_IDX_ENABLE, 8'hFF);
    // Stale latches would win priority over the new edge
    for (i = 0; i < 8; i++) begin
      tick(1);
      slow <= i[0];
      fm <= (i == 0);
      ext_n[i] <= 1'b0;
      tick(3);
      ext_n[i] <= 1'b1;
      if (i == 7) bus(1'b1, `ERICTL_IDX_ENABLE, 8'h7F);
      unmask;
      tick(i == 0 ? 30 : 0);
      fm <= 1'b0;
      expect_vec(1'b0, 6'h04 + i[5:0]);
    end
    // Edge latch outlives its enable bit until the mask recipe clears it
    tick(1);
    ext_n[2] <= 1'b0;
    tick(4);
    ext_n[2] <= 1'b1;
    bus(1'b1, `ERICTL_IDX_ENABLE, 8'h00);
    bus(1'b0, `ERICTL_IDX_PEND, 8'h00);
    chk({8'h00, rd}, 16'h0004);
    bus(1'b1, `ERICTL_IDX_SENSE, 8'h00);
    bus(1'b0, `ERICTL_IDX_PEND, 8'h00);
    chk({8'h00, rd}, 16'h0000);
    a = $unsigned($random(seed)) % 16;
    bus(1'b1, `ERICTL_IDX_SENSE, 8'h00);
    bus(1'b1, `ERICTL_IDX_ENABLE, 8'h40);
    bus(1'b1, `ERICTL_IDX_KEYLO, ~(8'h01 << a));
    bus(1'b1, `ERICTL_IDX_KEYHI, ~(8'h01 << (a - 8)));
    key_n[a] <= 1'b0;
    unmask;
    expect_vec(1'b0, 6'h0A);
    tick(1);
    key_n <= 16'hFFFF;
    a = $unsigned($random(seed)) % 26;
    b = (a + 1 + $unsigned($random(seed)) % 25) % 26;
    periph[a] <= 1'b1;
    periph[b] <= 1'b1;
    nm_n <= 1'b0;
    expect_vec(1'b0, 6'h03);
    for (i = 0; i < 2; i++) begin
      c = ((a < b) ^ i[0]) ? a : b;
      unmask;
      expect_vec(1'b0, 6'h0C + c[5:0]);
      tick(1);
      periph[c] <= 1'b0;
    end
    bus(1'b1, `ERICTL_IDX_SYSCTL, 8'h0D);
    nm_n <= 1'b1;
    expect_vec(1'b0, 6'h03);
    tick(1);
    wdn <= 1'b1;
    tick(1);
    wdn <= 1'b0;
    expect_vec(1'b0, 6'h03);
    bus(1'b0, `ERICTL_IDX_STAT, 8'h00);
    chk({8'h00, rd}, 16'h0003);
    tick(1);
    wdr <= 1'b1;
    tick(1);
    wdr <= 1'b0;
    expect_vec(1'b1, 6'h00);
    bus(1'b0, `ERICTL_IDX_SYSCTL, 8'h00);
    chk({8'h00, rd}, 16'h0001);
    clr_n <= 1'b0;
    tick(12);
    clr_n <= 1'b1;
    expect_vec(1'b1, 6'h00);
    bus(1'b0, `ERICTL_IDX_SYSCTL, 8'h00);
    chk({8'h00, rd}, 16'h0009);
    conclude;
  end
endmodule
